// ---- logic/sso_defs.svh ----
`ifndef SSO_DEFS_SVH
`define SSO_DEFS_SVH
// Register address of the options register on the configuration port
`define SSO_OPTIONS_ADDR     5'h09
// Reset value: pipeline on, stalls off, done phase 4, tristate phase 6, write enable phase 5
`define SSO_OPTIONS_RESET    32'h02003fec
// Implemented bits; reserved positions read as zero
`define SSO_OPTIONS_MASK     32'h0bffffff
// Field positions
`define SSO_PWRDWN_BIT       27
`define SSO_DONE_PIPE_BIT    25
`define SSO_DRIVE_DONE_BIT   24
`define SSO_SINGLE_BIT       23
`define SSO_FREQ_MSB         22
`define SSO_FREQ_LSB         17
`define SSO_CLKSRC_MSB       16
`define SSO_CLKSRC_LSB       15
`define SSO_DONE_MSB         14
`define SSO_DONE_LSB         12
`define SSO_MATCH_MSB        11
`define SSO_MATCH_LSB        9
`define SSO_LOCK_MSB         8
`define SSO_LOCK_LSB         6
`define SSO_GTS_MSB          5
`define SSO_GTS_LSB          3
`define SSO_GWE_MSB          2
`define SSO_GWE_LSB          0
// Special phase codes
`define SSO_CODE_TRACK       3'h6
`define SSO_CODE_NONE        3'h7
// Last startup phase
`define SSO_LAST_PHASE       3'h7
`endif

// ---- logic/sso_pkg.sv ----
package sso_pkg;
  // Startup sequencer state
  typedef enum logic [1:0] {SSO_IDLE, SSO_RUN, SSO_DONE} sso_state_e;
  typedef logic [2:0] sso_phase_t;
endpackage

// ---- logic/sso_startup_options.sv ----
`timescale 1ns/100ps
`include "sso_defs.svh"
module sso_startup_options (
  input  wire logic               clock,                    // System clock 25 MHz
  input  wire logic               rst_n,                    // Async reset, active low
  input  wire logic               cfgWrite,                 // Config port write strobe
  input  wire logic               cfgRead,                  // Config port read strobe
  input  wire logic [4:0]         cfgAddr,                  // Config register address
  input  wire logic [31:0]        cfgWdata,                 // Config write data
  output logic      [31:0]        cfgRdata,                 // Config read data
  output logic                    cfgRvalid,                // Read data valid pulse
  input  wire logic               startupGo,                // Start the sequence, pulse
  input  wire logic               configClock,              // Config clock pin
  input  wire logic               userClock,                // User clock from capture block
  input  wire logic               testPortClock,            // Test port clock pin
  input  wire logic               completionInput,          // Completion pin level
  input  wire logic               calibMatch,               // Impedance calibration match
  input  wire logic               clockManagerLock,         // All clock managers locked
  input  wire logic               powerdownState,           // Device powerdown status
  input  wire logic               captureRequest,           // Capture request pulse
  input  wire logic               globalCaptureCmd,         // Global capture command pulse
  input  wire logic               captureResetCmd,          // Readback capture reset command
  input  wire logic               userWriteReq,             // User flip-flop write request
  input  wire logic [31:0]        userIoOut,                // User I/O output values
  input  wire logic [31:0]        userIoOe,                 // User I/O output enables
  output logic                    completionOut,            // Completion pin drive value
  output logic                    completionOe,             // Completion pin output enable
  output logic                    globalTristate,           // Global tristate, high active
  output logic                    globalWriteEnable,        // Global write enable
  output logic                    userWriteEn,              // Gated user write enable
  output logic [31:0]             ioOut,                    // Gated I/O values
  output logic [31:0]             ioOe,                     // Gated I/O enables
  output logic                    captureLoad,              // Load captured state pulse
  output logic [5:0]              masterClockFreqSelect,    // Master clock frequency code
  output logic [2:0]              startupPhaseGray,         // Phase in Gray code
  output logic                    endOfStartup              // Sequence finished
);
  import sso_pkg::*;

  // ************************************************************
  // Functions
  // ************************************************************
  // Phase to Gray code, shared by status and assertions
  function automatic logic [2:0] toGray(input logic [2:0] p);
    toGray = p ^ (p >> 1);
  endfunction
  // Release code 000..101 means phase code+1; 110/111 never match
  function automatic logic releaseHit(input logic [2:0] code, input logic [2:0] ph);
    releaseHit = (code < `SSO_CODE_TRACK) && (ph == 3'(code + 3'h1));
  endfunction

  // ************************************************************
  // Register and input synchronisers
  // ************************************************************
  logic [31:0] optionsReg, optionsNext;        // Options register
  logic [2:0]  cfgSyncReg, cfgSyncNext;        // Config clock synchroniser
  logic [2:0]  usrSyncReg, usrSyncNext;        // User clock synchroniser
  logic [2:0]  tstSyncReg, tstSyncNext;        // Test clock synchroniser
  logic [2:0]  doneSyncReg, doneSyncNext;      // Completion input synchroniser
  logic        donePipeReg, donePipeNext;      // Optional completion stage
  logic        doneLvlReg, doneLvlNext;        // Completion level once stages agree
  logic        clkPrevReg, clkPrevNext;        // Last agreed startup clock level
  logic        capArmedReg, capArmedNext;      // Single shot capture armed
  logic [31:0] rdataReg, rdataNext;            // Read data
  logic        rvalidReg, rvalidNext;          // Read valid
  logic        selClk;                         // Agreed selected clock level
  logic        stepEn;                         // One startup clock edge
  logic        doneSeen;                       // Completion level seen by sequencer

  // Field views
  logic [1:0] clkSrc;
  logic [2:0] doneCode, matchCode, lockCode, gtsCode, gweCode;
  assign clkSrc    = optionsReg[`SSO_CLKSRC_MSB:`SSO_CLKSRC_LSB];
  assign doneCode  = optionsReg[`SSO_DONE_MSB:`SSO_DONE_LSB];
  assign matchCode = optionsReg[`SSO_MATCH_MSB:`SSO_MATCH_LSB];
  assign lockCode  = optionsReg[`SSO_LOCK_MSB:`SSO_LOCK_LSB];
  assign gtsCode   = optionsReg[`SSO_GTS_MSB:`SSO_GTS_LSB];
  assign gweCode   = optionsReg[`SSO_GWE_MSB:`SSO_GWE_LSB];

  // Pins only count once stages two and three agree; first stage is never looked at
  always_comb begin
    selClk = clkPrevReg;
    case (clkSrc)
      2'h0:    if (cfgSyncReg[1] == cfgSyncReg[2]) selClk = cfgSyncReg[2];
      2'h1:    if (usrSyncReg[1] == usrSyncReg[2]) selClk = usrSyncReg[2];
      default: if (tstSyncReg[1] == tstSyncReg[2]) selClk = tstSyncReg[2];
    endcase
  end
  assign stepEn = selClk && !clkPrevReg;

  // Reserved bits dropped on write; the completion stage is clocked by the step
  always_comb begin
    optionsNext  = optionsReg;
    if (cfgWrite && cfgAddr == `SSO_OPTIONS_ADDR) begin
      optionsNext = cfgWdata & `SSO_OPTIONS_MASK;
    end
    cfgSyncNext  = {cfgSyncReg[1:0], configClock};
    usrSyncNext  = {usrSyncReg[1:0], userClock};
    tstSyncNext  = {tstSyncReg[1:0], testPortClock};
    doneSyncNext = {doneSyncReg[1:0], completionInput};
    clkPrevNext  = selClk;
    // A one-cycle glitch on the pin never reaches the sequencer
    doneLvlNext  = (doneSyncReg[1] == doneSyncReg[2]) ? doneSyncReg[2] : doneLvlReg;
    donePipeNext = stepEn ? doneLvlReg : donePipeReg;
    rvalidNext   = cfgRead;
    rdataNext    = rdataReg;
    if (cfgRead) begin
      rdataNext = (cfgAddr == `SSO_OPTIONS_ADDR) ? optionsReg : 32'h0;
    end
  end
  assign doneSeen = optionsReg[`SSO_DONE_PIPE_BIT] ? donePipeReg : doneLvlReg;

  // ************************************************************
  // Startup sequencer
  // ************************************************************
  sso_state_e stateReg, stateNext;             // Sequencer state
  sso_phase_t phaseReg, phaseNext;             // Current phase 0..7
  logic       relDoneReg, relDoneNext;         // Completion released
  logic       gtsReg, gtsNext;                 // Tristate asserted
  logic       gweReg, gweNext;                 // Write enable active
  logic       stall;                           // Held in a wait phase

  // Stall in the selected phase until the awaited input is true; 111 never matches phase
  assign stall = (matchCode != `SSO_CODE_NONE && phaseReg == matchCode
                  && !calibMatch) ||
                 (lockCode != `SSO_CODE_NONE && phaseReg == lockCode
                  && !clockManagerLock);

  always_comb begin
    stateNext   = stateReg;
    phaseNext   = phaseReg;
    relDoneNext = relDoneReg;
    gtsNext     = gtsReg;
    gweNext     = gweReg;
    case (stateReg)
      SSO_IDLE: begin
        if (startupGo) begin
          stateNext = SSO_RUN;
        end
      end
      SSO_RUN: begin
        if (stepEn && !stall) begin
          phaseNext = 3'(phaseReg + 3'h1);
          if (releaseHit(doneCode, phaseNext)) relDoneNext = 1'b1;
          if (releaseHit(gtsCode, phaseNext)) gtsNext = 1'b0;
          if (releaseHit(gweCode, phaseNext)) gweNext = 1'b1;
          if (phaseNext == `SSO_LAST_PHASE) stateNext = SSO_DONE;
        end
      end
      SSO_DONE: begin
      end
      default: stateNext = SSO_IDLE;
    endcase
    // Tracking codes follow the completion level seen by the sequencer
    if (stateReg != SSO_IDLE && gtsCode == `SSO_CODE_TRACK) gtsNext = !doneSeen;
    if (stateReg != SSO_IDLE && gweCode == `SSO_CODE_TRACK) gweNext = doneSeen;
  end

  // ************************************************************
  // Capture and pin logic
  // ************************************************************
  logic capNext, complOutNext, complOeNext, wrNext;
  logic [31:0] ioOutNext, ioOeNext;
  always_comb begin
    capArmedNext = capArmedReg;
    capNext      = 1'b0;
    if (captureRequest || globalCaptureCmd) begin
      if (!optionsReg[`SSO_SINGLE_BIT]) begin
        capNext = 1'b1;
      end else if (capArmedReg) begin
        capNext      = 1'b1;
        capArmedNext = 1'b0;
      end
    end
    if (captureResetCmd) capArmedNext = 1'b1;
    // Powerdown role overrides the completion role
    if (optionsReg[`SSO_PWRDWN_BIT]) begin
      complOutNext = powerdownState;
      complOeNext  = optionsReg[`SSO_DRIVE_DONE_BIT] ? 1'b1 : !powerdownState;
    end else begin
      // Held low until released in both styles; active style then drives high
      complOutNext = relDoneReg && optionsReg[`SSO_DRIVE_DONE_BIT];
      complOeNext  = optionsReg[`SSO_DRIVE_DONE_BIT] || !relDoneReg;
    end
    wrNext    = userWriteReq && gweReg;
    ioOutNext = gtsReg ? 32'h0 : userIoOut;
    ioOeNext  = gtsReg ? 32'h0 : userIoOe;
  end

  // Register every group
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      optionsReg <= `SSO_OPTIONS_RESET;
      cfgSyncReg <= 3'h0; usrSyncReg <= 3'h0; tstSyncReg <= 3'h0; doneSyncReg <= 3'h0;
      donePipeReg <= 1'b0; clkPrevReg <= 1'b0; capArmedReg <= 1'b1;
      doneLvlReg <= 1'b0;
      rdataReg <= 32'h0; rvalidReg <= 1'b0;
      stateReg <= SSO_IDLE; phaseReg <= 3'h0;
      relDoneReg <= 1'b0; gtsReg <= 1'b1; gweReg <= 1'b0;
      captureLoad <= 1'b0; completionOut <= 1'b0; completionOe <= 1'b1;
      userWriteEn <= 1'b0; ioOut <= 32'h0; ioOe <= 32'h0;
      masterClockFreqSelect <= 6'h0; startupPhaseGray <= 3'h0; endOfStartup <= 1'b0;
    end else begin
      optionsReg <= optionsNext;
      cfgSyncReg <= cfgSyncNext; usrSyncReg <= usrSyncNext; tstSyncReg <= tstSyncNext;
      doneSyncReg <= doneSyncNext; donePipeReg <= donePipeNext; clkPrevReg <= clkPrevNext;
      doneLvlReg <= doneLvlNext;
      capArmedReg <= capArmedNext; rdataReg <= rdataNext; rvalidReg <= rvalidNext;
      stateReg <= stateNext; phaseReg <= phaseNext;
      relDoneReg <= relDoneNext; gtsReg <= gtsNext; gweReg <= gweNext;
      captureLoad <= capNext; completionOut <= complOutNext; completionOe <= complOeNext;
      userWriteEn <= wrNext; ioOut <= ioOutNext; ioOe <= ioOeNext;
      masterClockFreqSelect <= optionsReg[`SSO_FREQ_MSB:`SSO_FREQ_LSB];
      startupPhaseGray <= toGray(phaseReg);
      endOfStartup <= (stateReg == SSO_DONE);
    end
  end
  assign globalTristate    = gtsReg;
  assign globalWriteEnable = gweReg;
  assign cfgRdata          = rdataReg;
  assign cfgRvalid         = rvalidReg;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_gray_status: assert property (startupPhaseGray == toGray($past(phaseReg)))
    else $error("Phase status not Gray of phase");
  a_write_gate: assert property (userWriteEn |-> $past(gweReg))
    else $error("Write passed while write enable inactive");
  a_io_tristate: assert property ($past(gtsReg) |-> ioOe == 32'h0)
    else $error("I/O driven under tristate");
  a_stall_hold: assert property (stateReg == SSO_RUN && stall |=> $stable(phaseReg))
    else $error("Phase moved in stall");
  a_step_once: assert property (stateReg == SSO_RUN && !stepEn |=> $stable(phaseReg))
    else $error("Phase moved without clock edge");
  a_reserved_zero: assert property ((optionsReg & ~`SSO_OPTIONS_MASK) == 32'h0)
    else $error("Reserved bit stored");
  a_repeat_cap: assert property (!optionsReg[`SSO_SINGLE_BIT] && captureRequest
      |=> captureLoad)
    else $error("Capture missed in repeat mode");
  a_done_held: assert property (!optionsReg[`SSO_PWRDWN_BIT] && !relDoneReg
      |=> completionOe && !completionOut)
    else $error("Completion pin not held low");
  a_single_cap: assert property (optionsReg[`SSO_SINGLE_BIT] && !capArmedReg && !captureResetCmd
      |=> !captureLoad)
    else $error("Capture while disarmed");
  a_done_release: assert property (stateReg == SSO_RUN && stepEn && !stall
      && releaseHit(doneCode, 3'(phaseReg + 3'h1)) |=> relDoneReg)
    else $error("Completion not released");
  a_freq_out: assert property (##1 masterClockFreqSelect == $past(optionsReg[22:17]))
    else $error("Frequency select mismatch");
  c_finish: cover property (stateReg == SSO_RUN ##1 stateReg == SSO_DONE);
  c_stall: cover property (stateReg == SSO_RUN && stall && stepEn);
  c_single: cover property (optionsReg[`SSO_SINGLE_BIT] && captureLoad);
endmodule // sso_startup_options

// ---- verification/sso_host_model.sv ----
`timescale 1ns/100ps
// ****************************************
// Configuration host and board model
// ****************************************
module sso_host_model (
  input  wire logic        clock,           // System clock
  input  wire logic        clkRun,          // Let the config clock run
  input  wire logic        completionOut,   // Device drive value
  input  wire logic        completionOe,    // Device drive enable
  output logic             cfgWrite,        // Write strobe
  output logic             cfgRead,         // Read strobe
  output logic [4:0]       cfgAddr,         // Register address
  output logic [31:0]      cfgWdata,        // Write data
  output logic             completionInput, // Resolved completion pin
  output logic             configClock      // Config clock, still outside runs
);
  initial begin
    {cfgWrite, cfgRead, cfgAddr, cfgWdata, configClock} = '0;
  end
  // Pull-up on the completion pin; open drain only ever pulls low
  assign completionInput = completionOe ? completionOut : 1'b1;
  // Slow clock, five system cycles a period, parked low when idle
  always #100 configClock <= clkRun ? ~configClock : 1'b0;
  // One write, held across exactly one sampling edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(negedge clock);
    {cfgWrite, cfgAddr, cfgWdata} = {1'b1, a, d};
    @(negedge clock);
    cfgWrite = 1'b0;
    cfgWdata = ~d; // Stale bus shows no old value
  endtask
  // One read request; data comes back on cfgRvalid
  task automatic rd(input logic [4:0] a);
    @(negedge clock);
    {cfgRead, cfgAddr} = {1'b1, a};
    @(negedge clock);
    cfgRead = 1'b0;
    repeat (2) @(negedge clock);
  endtask
endmodule // sso_host_model

// ---- verification/startup_sequence_options_tb.sv ----
`timescale 1ns/100ps
module startup_sequence_options_tb;
  logic        clock, rst_n, cfgWrite, cfgRead, cfgRvalid, startupGo, configClock;
  logic        completionInput, calibMatch, clockManagerLock, powerdownState;
  logic        captureRequest, globalCaptureCmd, captureResetCmd, userWriteReq;
  logic        completionOut, completionOe, globalTristate, globalWriteEnable;
  logic        userWriteEn, captureLoad, endOfStartup, clkRun;
  logic [4:0]  cfgAddr;
  logic [31:0] cfgWdata, cfgRdata, userIoOut, userIoOe, ioOut, ioOe, v;
  logic [5:0]  masterClockFreqSelect, f;
  logic [2:0]  startupPhaseGray;
  logic [31:0] expQ[$];  // Expected read data, oldest first
  int          n_fail, compares, cyc, nLoad, base, seed;
  sso_startup_options u_dut (.clock(clock), .rst_n(rst_n), .cfgWrite(cfgWrite),
    .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .cfgRdata(cfgRdata),
    .cfgRvalid(cfgRvalid), .startupGo(startupGo), .configClock(configClock),
    .userClock(configClock), .testPortClock(1'b0), .completionInput(completionInput),
    .calibMatch(calibMatch), .clockManagerLock(clockManagerLock),
    .powerdownState(powerdownState), .captureRequest(captureRequest),
    .globalCaptureCmd(globalCaptureCmd), .captureResetCmd(captureResetCmd),
    .userWriteReq(userWriteReq), .userIoOut(userIoOut), .userIoOe(userIoOe),
    .completionOut(completionOut), .completionOe(completionOe),
    .globalTristate(globalTristate), .globalWriteEnable(globalWriteEnable),
    .userWriteEn(userWriteEn), .ioOut(ioOut), .ioOe(ioOe), .captureLoad(captureLoad),
    .masterClockFreqSelect(masterClockFreqSelect), .startupPhaseGray(startupPhaseGray),
    .endOfStartup(endOfStartup));
  sso_host_model u_host (.clock(clock), .clkRun(clkRun), .completionOut(completionOut),
    .completionOe(completionOe), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
    .cfgAddr(cfgAddr), .cfgWdata(cfgWdata), .completionInput(completionInput),
    .configClock(configClock));
  // ****************************************
  // Clock, timeout and monitors
  // ****************************************
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Run should take about 750 cycles; a hang is cut off well above that
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("[ERR] %0t timeout", $time);
      print_verdict();
    end
  end
  // Read monitor takes the oldest note off the queue
  always @(negedge clock) begin
    if (cfgRvalid === 1'b1) begin
      if (expQ.size() == 0) check(1'b1, 1'b0);
      else check(cfgRdata, expQ.pop_front());
    end
  end
  always @(negedge clock) if (captureLoad === 1'b1) nLoad++;
  // ****************************************
  // Helper tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rd_exp(input logic [4:0] a, input logic [31:0] e);
    expQ.push_back(e);
    u_host.rd(a);
  endtask
  task automatic restart(input logic [31:0] cfg);
    @(negedge clock) {rst_n, clkRun} = 2'b00;
    @(negedge clock) rst_n = 1'b1;
    u_host.wr(5'h09, cfg);
    @(negedge clock) startupGo = 1'b1;
    @(negedge clock) {startupGo, clkRun} = 2'b01;
  endtask
  task automatic wait_end();
    for (int i = 0; i < 1000 && endOfStartup !== 1'b1; i++) @(negedge clock);
    check(endOfStartup, 1'b1);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(negedge clock) {captureResetCmd, globalCaptureCmd, captureRequest} = m;
    @(negedge clock) {captureResetCmd, globalCaptureCmd, captureRequest} = 3'h0;
    repeat (3) @(negedge clock);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 19;
    {rst_n, startupGo, powerdownState, captureRequest, globalCaptureCmd} = '0;
    {captureResetCmd, clkRun, calibMatch, clockManagerLock, userWriteReq} = 5'h0f;
    userIoOut = $random(seed);
    userIoOe = 32'hffffffff;
    repeat (8) @(posedge clock);
    @(negedge clock) rst_n = 1'b1;
    rd_exp(5'h09, 32'h02003fec);
    rd_exp(5'h0a, 32'h0);
    v = $random(seed);
    u_host.wr(5'h09, v);
    rd_exp(5'h09, v & 32'h0bffffff);
    check(masterClockFreqSelect, v[22:17]);
    $display("test registers done");
    f = $random(seed);
    restart({9'h004, f, 2'b00, 3'h3, 3'h2, 3'h5, 3'h4, 3'h5});
    check(ioOe, 32'h0);
    check(userWriteEn, 1'b0);
    {calibMatch, clockManagerLock} = 2'b00;
    repeat (200) @(negedge clock);
    check(startupPhaseGray, 3'h3);
    check(completionInput, 1'b0);
    calibMatch = 1'b1;
    repeat (200) @(negedge clock);
    check(startupPhaseGray, 3'h7);
    check(globalTristate, 1'b0);
    check(globalWriteEnable, 1'b0);
    clockManagerLock = 1'b1;
    wait_end();
    check(startupPhaseGray, 3'h4);
    check(globalWriteEnable, 1'b1);
    check(ioOe, userIoOe);
    check(ioOut, userIoOut);
    check(userWriteEn, 1'b1);
    check(completionInput, 1'b1);
    $display("test stalls done");
    restart({9'h002, 6'h00, 2'b10, 3'h0, 3'h7, 3'h7, 3'h7, 3'h6});
    repeat (200) @(negedge clock);
    check(startupPhaseGray, 3'h0);
    check(completionInput, 1'b0);
    check(globalWriteEnable, 1'b0);
    u_host.wr(5'h09, {9'h002, 6'h00, 2'b01, 3'h0, 3'h7, 3'h7, 3'h7, 3'h6});
    wait_end();
    check(globalTristate, 1'b1);
    check(ioOe, 32'h0);
    check(globalWriteEnable, 1'b1);
    check({completionOe, completionOut}, 2'b11);
    $display("test release codes done");
    base = nLoad;
    for (int i = 0; i < 3; i++) pulse(3'h1);
    pulse(3'h2);
    check(32'(nLoad - base), 32'h4);
    u_host.wr(5'h09, 32'h02803fec);
    base = nLoad;
    for (int i = 0; i < 3; i++) pulse(3'h1);
    check(32'(nLoad - base), 32'h1);
    pulse(3'h4);
    pulse(3'h1);
    check(32'(nLoad - base), 32'h2);
    $display("test capture done");
    u_host.wr(5'h09, 32'h0a003fec);
    repeat (4) @(negedge clock);
    check(completionInput, 1'b0);
    powerdownState = 1'b1;
    repeat (4) @(negedge clock);
    check(completionInput, 1'b1);
    $display("test powerdown done");
    print_verdict();
  end
endmodule // startup_sequence_options_tb
